// ===== rtl/dcv_pkg.sv
package dcv_pkg;

  // Device clock and watchdog timeout
  localparam int CLK_MHZ       = 250;
  localparam int WD_TIMEOUT_US = 100;  // Plain default, the part leaves it open

  // Register map, byte addresses on the AXI4-Lite slave
  localparam int         AW        = 8;
  localparam logic [7:0] OFS_VCMD0 = 8'h00;
  localparam logic [7:0] OFS_VCMD1 = 8'h04;
  localparam logic [7:0] OFS_CTRL  = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0c;
  localparam logic [7:0] OFS_DIAG0 = 8'h10;
  localparam logic [7:0] OFS_DIAG1 = 8'h14;
  localparam logic [7:0] OFS_DIAG2 = 8'h18;
  localparam logic [7:0] OFS_LIVE  = 8'h1c;
  localparam logic [7:0] WORD_MASK = 8'hfc;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Gate vector order, low side below high side of each phase
  localparam int G_LS_A = 0;
  localparam int G_HS_A = 1;
  localparam int G_LS_B = 2;
  localparam int G_HS_B = 3;

  typedef struct packed {
    logic test_logic_ov;
    logic test_boot_uv;
    logic test_supply_ov;
    logic test_supply_uv;
    logic test_aux_reg_ov;
    logic test_aux_reg_uv;
    logic test_overtemp;
  } dcv_vcmd0_t;

  typedef struct packed {
    logic test_overcurrent;
    logic test_drain_src_ov;
    logic test_gate_uv;
  } dcv_vcmd1_t;

  typedef struct packed {
    logic       enable_watchdog_mode_sel;
    logic [3:0] gate_cmd;
  } dcv_ctrl_t;

  typedef struct packed {
    logic enable_watchdog_expired;
    logic logic_pin_ov_fault;
    logic overtemp_fault;
  } dcv_stat_t;

  typedef struct packed {
    logic aux_reg_ov_fault;
    logic aux_reg_uv_fault;
    logic hs_b_gate_uv;
    logic ls_b_gate_uv;
    logic hs_a_gate_uv;
    logic ls_a_gate_uv;
  } dcv_diag0_t;

  typedef struct packed {
    logic hs_b_drain_src_ov;
    logic ls_b_drain_src_ov;
    logic hs_a_drain_src_ov;
    logic ls_a_drain_src_ov;
  } dcv_diag1_t;

  typedef struct packed {
    logic overcurrent_b_fault;
    logic overcurrent_a_fault;
    logic boot_b_undervolt;
    logic boot_a_undervolt;
    logic supply_ov_fault;
    logic supply_uv_fault;
  } dcv_diag2_t;

  typedef struct packed {
    logic wd_running;
    logic gate_en;
    logic fault_flag;
  } dcv_live_t;

  // Raw comparator outputs from the analog side
  typedef struct packed {
    logic [3:0] ds_ov;
    logic [3:0] gate_uv;
    logic       boot_b;
    logic       boot_a;
    logic       oc_b;
    logic       oc_a;
    logic       logic_ov;
    logic       sup_ov;
    logic       sup_uv;
    logic       aux_ov;
    logic       aux_uv;
    logic       ot;
  } dcv_cmp_t;

  typedef enum logic [1:0] {
    WD_IDLE    = 2'b00,
    WD_RUN     = 2'b01,
    WD_EXPIRED = 2'b10
  } dcv_wd_state_t;

endpackage

// ===== rtl/dcv_sticky.sv
module dcv_sticky #(
  parameter int W = 1
) (
  input  wire logic         i_clk,   // Device clock
  input  wire logic         i_rstn,  // Async reset, active low
  input  wire logic [W-1:0] i_set,   // Fault seen this cycle
  input  wire logic [W-1:0] i_clr,   // Write-one-to-clear strobe
  output logic      [W-1:0] o_bits   // Latched faults
);

  logic [W-1:0] bits_r;
  logic [W-1:0] bits_nxt;

  // Set beats a clear landing in the same cycle
  always_comb begin
    bits_nxt = (bits_r & ~i_clr) | i_set;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bits_r <= '0;
    end else begin
      bits_r <= bits_nxt;
    end
  end

  assign o_bits = bits_r;

  AST_STICKY_HOLD: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    ##1 (($past(bits_r) & ~$past(i_clr) & ~bits_r) == '0))
    else $error("Latched fault dropped without a clear");

  AST_SET_WINS: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (|i_set) |=> ((bits_r & $past(i_set)) == $past(i_set)))
    else $error("Fault event lost");

endmodule // dcv_sticky

// ===== rtl/dcv_diag_verify.sv
module dcv_diag_verify #(
  parameter int P_WD_CYCLES = dcv_pkg::WD_TIMEOUT_US * dcv_pkg::CLK_MHZ
) (
  input  wire logic                     i_clk,             // 250 MHz
  input  wire logic                     i_rstn,            // Async, active low
  input  wire logic [dcv_pkg::AW-1:0]   i_s_axi_awaddr,    // Write address
  input  wire logic                     i_s_axi_awvalid,   // Write address valid
  output logic                          o_s_axi_awready,   // Write address ready
  input  wire logic [31:0]              i_s_axi_wdata,     // Write data
  input  wire logic [3:0]               i_s_axi_wstrb,     // Byte strobes
  input  wire logic                     i_s_axi_wvalid,    // Write data valid
  output logic                          o_s_axi_wready,    // Write data ready
  output logic [1:0]                    o_s_axi_bresp,     // Write response
  output logic                          o_s_axi_bvalid,    // Write response valid
  input  wire logic                     i_s_axi_bready,    // Write response ready
  input  wire logic [dcv_pkg::AW-1:0]   i_s_axi_araddr,    // Read address
  input  wire logic                     i_s_axi_arvalid,   // Read address valid
  output logic                          o_s_axi_arready,   // Read address ready
  output logic [31:0]                   o_s_axi_rdata,     // Read data
  output logic [1:0]                    o_s_axi_rresp,     // Read response
  output logic                          o_s_axi_rvalid,    // Read data valid
  input  wire logic                     i_s_axi_rready,    // Read data ready
  input  wire dcv_pkg::dcv_cmp_t        i_cmp,             // Raw comparator outputs
  input  wire logic [3:0]               i_gate_in,         // Gate command pins
  input  wire logic                     i_enable,          // Enable pin
  output logic [3:0]                    o_gate_drv,        // Gate drive commands
  output logic                          o_fault_flag,      // General fault, high active
  output logic [1:0]                    o_amp_full_scale   // Force sense amps, {b,a}
);

  localparam int CW = $bits(dcv_pkg::dcv_cmp_t);
  localparam int SW = CW + 5;

  // Pin synchronisers
  logic [SW-1:0] sy1_r;
  logic [SW-1:0] sy2_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else begin
      sy1_r <= {i_cmp, i_enable, i_gate_in};
      sy2_r <= sy1_r;
    end
  end

  dcv_pkg::dcv_cmp_t cmp_s;
  logic              en_s;
  logic [3:0]        gin_s;

  assign cmp_s = dcv_pkg::dcv_cmp_t'(sy2_r[SW-1:5]);
  assign en_s  = sy2_r[4];
  assign gin_s = sy2_r[3:0];

  // Word address, shared by read and write decode
  function automatic logic [7:0] word_of(input logic [dcv_pkg::AW-1:0] a);
    word_of = a & dcv_pkg::WORD_MASK;
  endfunction

  function automatic logic mapped(input logic [dcv_pkg::AW-1:0] a);
    mapped = (word_of(a) <= dcv_pkg::OFS_LIVE);
  endfunction

  // Opposite switch of the same phase
  function automatic logic [3:0] other_side(input logic [3:0] on);
    logic [3:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i] = on[i ^ 1];
    end
    other_side = r;
  endfunction

  // Software-written state
  dcv_pkg::dcv_vcmd0_t vcmd0_r, vcmd0_nxt;
  dcv_pkg::dcv_vcmd1_t vcmd1_r, vcmd1_nxt;
  dcv_pkg::dcv_ctrl_t  ctrl_r, ctrl_nxt;
  dcv_pkg::dcv_stat_t  stat_q, stat_set, stat_clr;
  dcv_pkg::dcv_diag0_t diag0_q, diag0_set, diag0_clr;
  dcv_pkg::dcv_diag1_t diag1_q, diag1_set, diag1_clr;
  dcv_pkg::dcv_diag2_t diag2_q, diag2_set, diag2_clr;
  dcv_pkg::dcv_live_t  live;

  logic       wr_fire;
  logic       wr_lane0;
  logic [7:0] wr_word;

  // Address and data are taken together, only once both are offered
  assign wr_fire         = i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_bvalid;
  assign o_s_axi_awready = wr_fire;
  assign o_s_axi_wready  = wr_fire;
  assign wr_lane0        = wr_fire & i_s_axi_wstrb[0];
  assign wr_word         = word_of(i_s_axi_awaddr);

  always_comb begin
    vcmd0_nxt = vcmd0_r;
    vcmd1_nxt = vcmd1_r;
    ctrl_nxt  = ctrl_r;
    stat_clr  = '0;
    diag0_clr = '0;
    diag1_clr = '0;
    diag2_clr = '0;
    if (wr_lane0) begin
      case (wr_word)
        dcv_pkg::OFS_VCMD0: begin
          vcmd0_nxt = i_s_axi_wdata[$bits(dcv_pkg::dcv_vcmd0_t)-1:0];
        end
        dcv_pkg::OFS_VCMD1: begin
          vcmd1_nxt = i_s_axi_wdata[$bits(dcv_pkg::dcv_vcmd1_t)-1:0];
        end
        dcv_pkg::OFS_CTRL: begin
          ctrl_nxt = i_s_axi_wdata[$bits(dcv_pkg::dcv_ctrl_t)-1:0];
        end
        dcv_pkg::OFS_STAT: begin
          stat_clr = i_s_axi_wdata[$bits(dcv_pkg::dcv_stat_t)-1:0];
        end
        dcv_pkg::OFS_DIAG0: begin
          diag0_clr = i_s_axi_wdata[$bits(dcv_pkg::dcv_diag0_t)-1:0];
        end
        dcv_pkg::OFS_DIAG1: begin
          diag1_clr = i_s_axi_wdata[$bits(dcv_pkg::dcv_diag1_t)-1:0];
        end
        dcv_pkg::OFS_DIAG2: begin
          diag2_clr = i_s_axi_wdata[$bits(dcv_pkg::dcv_diag2_t)-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      vcmd0_r <= '0;
      vcmd1_r <= '0;
      ctrl_r  <= '0;
    end else begin
      vcmd0_r <= vcmd0_nxt;
      vcmd1_r <= vcmd1_nxt;
      ctrl_r  <= ctrl_nxt;
    end
  end

  // Comparators as seen by the fault logic, test forcing ORed in
  logic [3:0]        gate_on;
  logic [3:0]        force_cross;
  dcv_pkg::dcv_cmp_t eff;
  logic              flag_nxt;

  assign gate_on     = ctrl_r.gate_cmd | gin_s;
  assign force_cross = other_side(gate_on);

  always_comb begin
    eff          = cmp_s;
    eff.ot       = cmp_s.ot | vcmd0_r.test_overtemp;
    eff.aux_uv   = cmp_s.aux_uv | vcmd0_r.test_aux_reg_uv;
    eff.aux_ov   = cmp_s.aux_ov | vcmd0_r.test_aux_reg_ov;
    eff.sup_uv   = cmp_s.sup_uv | vcmd0_r.test_supply_uv;
    eff.sup_ov   = cmp_s.sup_ov | vcmd0_r.test_supply_ov;
    eff.logic_ov = cmp_s.logic_ov | vcmd0_r.test_logic_ov;
    // Only while the opposite switch is on, so gates off also releases
    eff.gate_uv  = cmp_s.gate_uv | ({4{vcmd1_r.test_gate_uv}} & force_cross);
    eff.ds_ov    = cmp_s.ds_ov | ({4{vcmd1_r.test_drain_src_ov}} & force_cross);
    eff.boot_a   = cmp_s.boot_a | (vcmd0_r.test_boot_uv & gate_on[dcv_pkg::G_HS_A]);
    eff.boot_b   = cmp_s.boot_b | (vcmd0_r.test_boot_uv & gate_on[dcv_pkg::G_HS_B]);
    // Flag is a level: it follows the live comparators, not the latches
    flag_nxt = |eff;
  end

  // Enable watchdog
  dcv_pkg::dcv_wd_state_t wd_state_r, wd_state_nxt;
  logic [31:0]            wd_cnt_r, wd_cnt_nxt;
  logic                   en_prev_r;
  logic                   en_edge;
  logic                   wd_expire;
  logic                   gate_en;

  assign en_edge = en_s ^ en_prev_r;

  always_comb begin
    wd_state_nxt = wd_state_r;
    wd_cnt_nxt   = wd_cnt_r;
    wd_expire    = 1'b0;
    if (!ctrl_r.enable_watchdog_mode_sel) begin
      wd_state_nxt = dcv_pkg::WD_IDLE;
      wd_cnt_nxt   = '0;
    end else begin
      case (wd_state_r)
        dcv_pkg::WD_IDLE, dcv_pkg::WD_EXPIRED: begin
          if (en_edge) begin
            wd_state_nxt = dcv_pkg::WD_RUN;
            wd_cnt_nxt   = '0;
          end
        end
        dcv_pkg::WD_RUN: begin
          if (en_edge) begin
            wd_cnt_nxt = '0;
          end else if (wd_cnt_r == 32'(P_WD_CYCLES - 1)) begin
            wd_state_nxt = dcv_pkg::WD_EXPIRED;
            wd_expire    = 1'b1;
          end else begin
            wd_cnt_nxt = wd_cnt_r + 32'h1;
          end
        end
        default: begin
          wd_state_nxt = dcv_pkg::WD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wd_state_r <= dcv_pkg::WD_IDLE;
      wd_cnt_r   <= '0;
      en_prev_r  <= 1'b0;
    end else begin
      wd_state_r <= wd_state_nxt;
      wd_cnt_r   <= wd_cnt_nxt;
      en_prev_r  <= en_s;
    end
  end

  // In watchdog mode the gate drives run only between an enable change and expiry
  assign gate_en = ctrl_r.enable_watchdog_mode_sel ? (wd_state_r == dcv_pkg::WD_RUN) : en_s;

  // Fault latches
  assign stat_set  = {wd_expire, eff.logic_ov, eff.ot};
  assign diag0_set = {eff.aux_ov, eff.aux_uv, eff.gate_uv};
  assign diag1_set = eff.ds_ov;
  // Overcurrent bits come from the real comparators fed by the forced amps
  assign diag2_set = {cmp_s.oc_b, cmp_s.oc_a, eff.boot_b, eff.boot_a, eff.sup_ov, eff.sup_uv};

  dcv_sticky #(.W($bits(dcv_pkg::dcv_stat_t))) u_stat (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_set  (stat_set),
    .i_clr  (stat_clr),
    .o_bits (stat_q)
  );

  dcv_sticky #(.W($bits(dcv_pkg::dcv_diag0_t))) u_diag0 (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_set  (diag0_set),
    .i_clr  (diag0_clr),
    .o_bits (diag0_q)
  );

  dcv_sticky #(.W($bits(dcv_pkg::dcv_diag1_t))) u_diag1 (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_set  (diag1_set),
    .i_clr  (diag1_clr),
    .o_bits (diag1_q)
  );

  dcv_sticky #(.W($bits(dcv_pkg::dcv_diag2_t))) u_diag2 (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_set  (diag2_set),
    .i_clr  (diag2_clr),
    .o_bits (diag2_q)
  );

  // Registered pin outputs
  logic       flag_r;
  logic [3:0] gate_drv_r;
  logic [1:0] amp_fs_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_r     <= 1'b0;
      gate_drv_r <= '0;
      amp_fs_r   <= '0;
    end else begin
      flag_r     <= flag_nxt;
      gate_drv_r <= gate_on & {4{gate_en}};
      amp_fs_r   <= {2{vcmd1_r.test_overcurrent}};
    end
  end

  assign o_fault_flag     = flag_r;
  assign o_gate_drv       = gate_drv_r;
  assign o_amp_full_scale = amp_fs_r;
  assign live             = {wd_state_r == dcv_pkg::WD_RUN, gate_en, flag_r};

  // Bus responses
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        rd_fire;

  assign rd_fire         = i_s_axi_arvalid & ~rvalid_r;
  assign o_s_axi_arready = rd_fire;

  always_comb begin
    bvalid_nxt = bvalid_r & ~i_s_axi_bready;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r & ~i_s_axi_rready;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = mapped(i_s_axi_awaddr) ? dcv_pkg::RESP_OKAY : dcv_pkg::RESP_SLVERR;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = mapped(i_s_axi_araddr) ? dcv_pkg::RESP_OKAY : dcv_pkg::RESP_SLVERR;
      case (word_of(i_s_axi_araddr))
        dcv_pkg::OFS_VCMD0: rdata_nxt = 32'(vcmd0_r);
        dcv_pkg::OFS_VCMD1: rdata_nxt = 32'(vcmd1_r);
        dcv_pkg::OFS_CTRL:  rdata_nxt = 32'(ctrl_r);
        dcv_pkg::OFS_STAT:  rdata_nxt = 32'(stat_q);
        dcv_pkg::OFS_DIAG0: rdata_nxt = 32'(diag0_q);
        dcv_pkg::OFS_DIAG1: rdata_nxt = 32'(diag1_q);
        dcv_pkg::OFS_DIAG2: rdata_nxt = 32'(diag2_q);
        dcv_pkg::OFS_LIVE:  rdata_nxt = 32'(live);
        default:            rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= dcv_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r  <= dcv_pkg::RESP_OKAY;
      rdata_r  <= '0;
    end else begin
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp  = bresp_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rresp  = rresp_r;
  assign o_s_axi_rdata  = rdata_r;

  // Checks
  sequence s_gate_low_a;
    vcmd1_r.test_gate_uv && gate_on[dcv_pkg::G_LS_A];
  endsequence

  sequence s_ds_high_b;
    vcmd1_r.test_drain_src_ov && gate_on[dcv_pkg::G_HS_B];
  endsequence

  sequence s_wd_last;
    wd_state_r == dcv_pkg::WD_RUN && wd_cnt_r == 32'(P_WD_CYCLES - 1) && !en_edge;
  endsequence

  AST_OT_FORCE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    vcmd0_r.test_overtemp |=> o_fault_flag && stat_q.overtemp_fault)
    else $error("Overtemp test did not flag and latch");

  AST_AUX_UV: assert property (@(posedge i_clk) disable iff (!i_rstn)
    vcmd0_r.test_aux_reg_uv |=> o_fault_flag && diag0_q.aux_reg_uv_fault)
    else $error("Aux undervolt test did not latch");

  AST_AUX_OV: assert property (@(posedge i_clk) disable iff (!i_rstn)
    vcmd0_r.test_aux_reg_ov |=> o_fault_flag && diag0_q.aux_reg_ov_fault)
    else $error("Aux overvolt test did not latch");

  AST_SUP_OV: assert property (@(posedge i_clk) disable iff (!i_rstn)
    vcmd0_r.test_supply_ov |=> o_fault_flag && diag2_q.supply_ov_fault)
    else $error("Supply overvolt test did not latch");

  AST_GATE_UV: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_gate_low_a |=> o_fault_flag && diag0_q.hs_a_gate_uv)
    else $error("Gate undervolt high side not latched");

  AST_DS_LOW: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_ds_high_b |=> diag1_q.ls_b_drain_src_ov)
    else $error("Drain-source low side not latched");

  AST_BOOT_B: assert property (@(posedge i_clk) disable iff (!i_rstn)
    vcmd0_r.test_boot_uv && gate_on[dcv_pkg::G_HS_B] |=> diag2_q.boot_b_undervolt)
    else $error("Bootstrap undervolt not latched");

  AST_FLAG_DROP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (vcmd0_r == '0 && vcmd1_r.test_gate_uv == 1'b0 && cmp_s == '0
     && vcmd1_r.test_drain_src_ov == 1'b0) |=> !o_fault_flag)
    else $error("Fault flag held without a cause");

  AST_WD_EXPIRE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_wd_last |=> stat_q.enable_watchdog_expired && wd_state_r == dcv_pkg::WD_EXPIRED
                  ##1 o_gate_drv == '0)
    else $error("Watchdog expiry not latched or gates left on");

  AST_AMP_FS: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $fell(vcmd1_r.test_overcurrent) |=> o_amp_full_scale == '0 ##1 o_amp_full_scale == '0)
    else $error("Sense amps not restored");

  AST_BRESP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_fire |=> o_s_axi_bvalid)
    else $error("Write response missing");

endmodule // dcv_diag_verify

// ===== tb/dcv_analog_model.sv
module dcv_analog_model (
  input  wire logic        i_clk,    // Device clock
  input  wire logic        i_rstn,   // Async reset, active low
  input  wire logic [1:0]  i_amp_fs, // Amps forced to full scale {b,a}
  input  wire logic        i_thr_ok, // Threshold plus offset within full scale
  output dcv_pkg::dcv_cmp_t o_cmp    // Comparator outputs
);
  timeunit 1ns;
  timeprecision 1ps;
  // Only the current comparators follow the amps; every other one sits healthy
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cmp <= '0;
    end else begin
      o_cmp <= '0;
      o_cmp.oc_a <= i_amp_fs[0] & i_thr_ok;
      o_cmp.oc_b <= i_amp_fs[1] & i_thr_ok;
    end
  end
endmodule // dcv_analog_model

// ===== tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD = 20;
  logic i_clk, i_rstn, awv, wv, brdy, arv, rrdy, ena, thr_ok;
  logic awr, wr_rdy, bv, arr, rv, flag;
  logic [7:0] awa, ara, ra [7];
  logic [31:0] wd, rdat, v, seed, rm [7];
  logic [1:0] bresp, rresp, rsp, amp_fs;
  logic [3:0] gin, gdrv, ws;
  dcv_pkg::dcv_cmp_t cmp;
  int fail_count, n_tests;

  dcv_diag_verify #(.P_WD_CYCLES(WD)) dut_u (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_rdy), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(brdy), .i_s_axi_araddr(ara),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdat),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rrdy), .i_cmp(cmp),
    .i_gate_in(gin), .i_enable(ena), .o_gate_drv(gdrv), .o_fault_flag(flag),
    .o_amp_full_scale(amp_fs));
  dcv_analog_model ana_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_amp_fs(amp_fs),
    .i_thr_ok(thr_ok), .o_cmp(cmp));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(inout int n);
    @(posedge i_clk);
    n++;
    if (n > 200) begin
      fail_count++;
      $display("unexpected at %0t: no answer", $time);
      give_verdict;
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge i_clk);
  endtask

  // Address and data go up together: the slave only takes them as a pair
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    n = 0;
    do tick(n); while (awr !== 1'b1 || wr_rdy !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    do tick(n); while (bv !== 1'b1);
    rsp = bresp;
    brdy <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge i_clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    n = 0;
    do tick(n); while (arr !== 1'b1);
    arv <= 1'b0;
    do tick(n); while (rv !== 1'b1);
    v = rdat;
    rsp = rresp;
    rrdy <= 1'b0;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Forced gate-UV and drain-source tests latch the opposite switch; the bootstrap test latches the commanded high side only
  function automatic logic [31:0] gexp(input int k, input int g);
    if (k == 2) return (g % 2 == 1) ? 32'h1 << (2 + g / 2) : 32'h0;
    return 32'h1 << (g ^ 1);
  endfunction

  initial begin
    {i_rstn, awv, wv, brdy, arv, rrdy, ena, thr_ok} = '0;
    {awa, ara, wd, gin} = '0;
    ws = 4'hf;
    fail_count = 0;
    n_tests = 0;
    seed = 32'd75;
    ra = '{dcv_pkg::OFS_STAT, dcv_pkg::OFS_DIAG0, dcv_pkg::OFS_DIAG0, dcv_pkg::OFS_DIAG2,
           dcv_pkg::OFS_DIAG2, 8'h00, dcv_pkg::OFS_STAT};
    rm = '{32'h1, 32'h10, 32'h20, 32'h1, 32'h2, 32'h0, 32'h2};
    wt(16);
    i_rstn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(8'(a * 4));
      chk(v, 32'h0);
    end
    seed = xs(seed);
    wr(dcv_pkg::OFS_CTRL, seed);
    rd(dcv_pkg::OFS_CTRL);
    chk(v, seed & 32'h1f);
    wr(dcv_pkg::OFS_CTRL, 32'h0);
    $display("test reset_and_ctrl done");
    for (int i = 0; i < 7; i++) begin
      if (i == 5) continue;
      wr(dcv_pkg::OFS_VCMD0, 32'h1 << i);
      wt(3);
      chk(32'(flag), 32'h1);
      wr(dcv_pkg::OFS_VCMD0, 32'h0);
      wt(3);
      chk(32'(flag), 32'h0);
      rd(ra[i]);
      chk(v & rm[i], rm[i]);
      wr(ra[i], rm[i]);
      rd(ra[i]);
      chk(v & rm[i], 32'h0);
    end
    $display("test forced_comparators done");
    for (int k = 0; k < 3; k++) begin
      for (int g = 0; g < 4; g++) begin
        seed = xs(seed);
        wr(k == 2 ? dcv_pkg::OFS_VCMD0 : dcv_pkg::OFS_VCMD1, k == 2 ? 32'h20 : 32'h1 << k);
        if (seed[0]) begin
          gin <= 4'h1 << g;
        end else begin
          wr(dcv_pkg::OFS_CTRL, 32'h1 << g);
        end
        wt(5);
        chk(32'(flag), 32'(gexp(k, g) != 0));
        // Either way out must drop the flag
        if (seed[1]) begin
          wr(k == 2 ? dcv_pkg::OFS_VCMD0 : dcv_pkg::OFS_VCMD1, 32'h0);
        end else begin
          gin <= 4'h0;
          wr(dcv_pkg::OFS_CTRL, 32'h0);
        end
        wt(5);
        chk(32'(flag), 32'h0);
        gin <= 4'h0;
        wr(dcv_pkg::OFS_CTRL, 32'h0);
        wr(k == 2 ? dcv_pkg::OFS_VCMD0 : dcv_pkg::OFS_VCMD1, 32'h0);
        rd(k == 0 ? dcv_pkg::OFS_DIAG0 : k == 1 ? dcv_pkg::OFS_DIAG1 : dcv_pkg::OFS_DIAG2);
        chk(v, gexp(k, g));
        wr(k == 0 ? dcv_pkg::OFS_DIAG0 : k == 1 ? dcv_pkg::OFS_DIAG1 : dcv_pkg::OFS_DIAG2,
           32'h3f);
      end
    end
    $display("test gate_tests done");
    for (int t = 1; t >= 0; t--) begin
      thr_ok <= t[0];
      wr(dcv_pkg::OFS_VCMD1, 32'h4);
      wt(4);
      chk(32'(amp_fs), 32'h3);
      wr(dcv_pkg::OFS_VCMD1, 32'h0);
      wt(4);
      chk(32'(amp_fs), 32'h0);
      rd(dcv_pkg::OFS_DIAG2);
      chk(v, t == 1 ? 32'h30 : 32'h0);
      wr(dcv_pkg::OFS_DIAG2, 32'h3f);
    end
    $display("test overcurrent done");
    wr(dcv_pkg::OFS_CTRL, 32'h11);
    ena <= 1'b1;
    wt(6);
    chk(32'(gdrv), 32'h1);
    wt(WD + 10);
    chk(32'(gdrv), 32'h0);
    rd(dcv_pkg::OFS_STAT);
    chk(v & 32'h4, 32'h4);
    $display("test watchdog done");
    rd(8'h20);
    chk(v, 32'h0);
    chk(32'(rsp), 32'(dcv_pkg::RESP_SLVERR));
    wr(8'h24, 32'hffffffff);
    chk(32'(rsp), 32'(dcv_pkg::RESP_SLVERR));
    // Low byte lane off: the write is answered but changes nothing
    ws <= 4'h0;
    wr(dcv_pkg::OFS_VCMD0, 32'h1);
    chk(32'(rsp), 32'(dcv_pkg::RESP_OKAY));
    ws <= 4'hf;
    rd(dcv_pkg::OFS_VCMD0);
    chk(v, 32'h0);
    chk(32'(rsp), 32'(dcv_pkg::RESP_OKAY));
    $display("test unmapped done");
    give_verdict;
  end
endmodule // tb
